// *** design/elc_cfg_top.sv ***
// elc_cfg_top: termination, jitter attenuator and transmit path configuration registers
// with the transmit datapath they steer
// assumes: host port on clk_sys; line clock and framer data arrive asynchronously on pins
// What this block does
// - tx termination 000 internal 75, 001 internal 120, 1xx external resistors
// - rx termination low bits: 000 internal 75, 001 internal 120, 1xx external
// - attenuator placement 00/10 unused, 01 transmit path, 11 receive path
// - attenuator depth 00 gives 128 bits, 01 gives 64, 1x gives 32
// - bandwidth bit clear gives 6.8 Hz corner, set gives 0.9 Hz
// - power down bit powers transmitter off and floats the line driver
// - data invert bit makes transmit inputs active low when set
// - edge bit clear samples on falling line clock edge, set on rising
// - mode 00 takes single-rail data through HDB3 encoder and shaper
// - mode 01 takes single-rail data, encodes AMI before shaping
// - mode 1x bypasses encoder; framer drives dual-rail data on both rails
// - monitor disable bit clear keeps driver failure monitor on, set turns off
// - high impedance bit, reset 1, floats only the driver; clear restores
// - template 0000 is 75 ohm, 0001 120 ohm, 11xx user waveform
`timescale 1ns/1ps
module elc_cfg_top
	import elc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [7:0]  hostAddr,
	input  wire logic        hostWrEn,
	input  wire logic        hostRdEn,
	input  wire logic [7:0]  hostWrData,
	output logic      [7:0]  hostRdData,
	output logic             hostRdValid,
	input  wire logic        txLineClock,
	input  wire logic        txSerialIn,
	input  wire logic        txPosRail,
	input  wire logic        txNegRail,
	input  wire logic        driverFaultPin,
	output logic             txLinePos,
	output logic             txLineNeg,
	output logic             txLineOeN,
	output logic             txPowerDown,
	output logic             driverFailAlarm,
	output term_type         txTermSel,
	output term_type         rxTermSel,
	output logic             jitTxPath,
	output logic             jitRxPath,
	output logic             jitLimitMode,
	output logic      [7:0]  jitDepthBits,
	output logic      [15:0] jitCornerMilliHz,
	output tmpl_type         tmplSel,
	output logic      [5:0]  ampScale
);
	logic [7:0] term_ff;
	logic [7:0] jitr_ff;
	logic [7:0] tpth_ff;
	logic [7:0] tdrv_ff;
	logic [7:0] tamp_ff;
	logic [7:0] nxt_rdData;
	logic [4:0] pinLvl;
	logic [4:0] pinRise;
	logic [4:0] pinFall;
	logic       txLinePos_ff;
	logic       txLineNeg_ff;
	logic       txLineOeN_ff;
	logic       drvAlarm_ff;
	logic [7:0] rdData_ff;
	logic       rdValid_ff;
	logic       wrTerm;
	logic       wrJitr;
	logic       wrTpth;
	logic       wrTdrv;
	logic       wrTamp;
	logic       driverOff;

	elc_tx_if tx ();

	// =====================================================
	// host writes; reserved bits are masked so they always hold zero
	assign wrTerm = hostWrEn && (hostAddr == ADDR_TERM);
	assign wrJitr = hostWrEn && (hostAddr == ADDR_JITR);
	assign wrTpth = hostWrEn && (hostAddr == ADDR_TPTH);
	assign wrTdrv = hostWrEn && (hostAddr == ADDR_TDRV);
	assign wrTamp = hostWrEn && (hostAddr == ADDR_TAMP);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			term_ff <= RST_TERM;
			jitr_ff <= RST_JITR;
			tpth_ff <= RST_TPTH;
			tdrv_ff <= RST_TDRV;
			tamp_ff <= RST_TAMP;
		end else begin
			if (wrTerm) begin
				term_ff <= hostWrData & MASK_TERM;
			end
			if (wrJitr) begin
				jitr_ff <= hostWrData & MASK_JITR;
			end
			if (wrTpth) begin
				tpth_ff <= hostWrData & MASK_TPTH;
			end
			if (wrTdrv) begin
				// top two bits dropped; software is expected to keep them zero
				tdrv_ff <= hostWrData & MASK_TDRV;
			end
			if (wrTamp) begin
				tamp_ff <= hostWrData & MASK_TAMP;
			end
		end
	end

	// =====================================================
	// host reads: data one cycle after the strobe, unmapped reads give zero
	always_comb begin
		unique case (hostAddr)
			ADDR_TERM: nxt_rdData = term_ff;
			ADDR_JITR: nxt_rdData = jitr_ff;
			ADDR_TPTH: nxt_rdData = tpth_ff;
			ADDR_TDRV: nxt_rdData = tdrv_ff;
			ADDR_TAMP: nxt_rdData = tamp_ff;
			default:   nxt_rdData = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rdData_ff  <= 8'h00;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= hostRdEn;
			if (hostRdEn) begin
				rdData_ff <= nxt_rdData;
			end
		end
	end

	assign hostRdData  = rdData_ff;
	assign hostRdValid = rdValid_ff;

	// =====================================================
	// termination decode
	function automatic term_type termDecode(input logic [2:0] code);
		if (code[2]) begin
			termDecode = TERM_EXT;
		end else if (code == 3'h1) begin
			termDecode = TERM_INT120;
		end else begin
			// 010 and 011 are undefined; internal 75 ohm is the safe choice
			termDecode = TERM_INT75;
		end
	endfunction

	assign txTermSel = termDecode(term_ff[TTERM_LSB +: 3]);
	assign rxTermSel = termDecode(term_ff[RTERM_LSB +: 3]);

	// =====================================================
	// jitter attenuator settings
	assign jitLimitMode = jitr_ff[JLIM_BIT];
	assign jitTxPath    = (jitr_ff[JPLACE_LSB +: 2] == 2'h1);
	assign jitRxPath    = (jitr_ff[JPLACE_LSB +: 2] == 2'h3);

	always_comb begin
		if (jitr_ff[JDEPTH_LSB + 1]) begin
			jitDepthBits = DEPTH_32;
		end else if (jitr_ff[JDEPTH_LSB]) begin
			jitDepthBits = DEPTH_64;
		end else begin
			jitDepthBits = DEPTH_128;
		end
	end

	assign jitCornerMilliHz = jitr_ff[JCORN_BIT] ? CORNER_LO : CORNER_HI;

	// =====================================================
	// template and amplitude
	always_comb begin
		unique case (tdrv_ff[TMPL_LSB +: 4])
			4'h0:                   tmplSel = TMPL_75;
			4'h1:                   tmplSel = TMPL_120;
			4'hC, 4'hD, 4'hE, 4'hF: tmplSel = TMPL_USER;
			default:                tmplSel = TMPL_RSVD;
		endcase
	end

	assign ampScale = tamp_ff[5:0];

	// =====================================================
	// pin inputs: line clock, serial data, both rails, driver fault sense
	elc_in_sync #(
		.W (5)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pinIn   ({driverFaultPin, txNegRail, txPosRail, txSerialIn, txLineClock}),
		.level   (pinLvl),
		.rise    (pinRise),
		.fall    (pinFall)
	);

	assign tx.mode      = tpth_ff[TMODE_LSB +: 2];
	assign tx.inv       = tpth_ff[TINV_BIT];
	assign tx.edgeSel   = tpth_ff[TEDGE_BIT];
	assign tx.powerDown = tpth_ff[TPD_BIT];
	assign txPowerDown  = tpth_ff[TPD_BIT];

	elc_tx_encoder u_enc (
		.clk_sys    (clk_sys),
		.nrst       (nrst),
		.sampleRise (pinRise[0]),
		.sampleFall (pinFall[0]),
		.dataIn     (pinLvl[1]),
		.posIn      (pinLvl[2]),
		.negIn      (pinLvl[3]),
		.tx         (tx)
	);

	// =====================================================
	// line driver: high impedance floats only the driver, encoder keeps running
	assign driverOff = tpth_ff[TPD_BIT] || tdrv_ff[HIZ_BIT];

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			txLinePos_ff <= 1'b0;
			txLineNeg_ff <= 1'b0;
			txLineOeN_ff <= 1'b1;
		end else begin
			txLinePos_ff <= tx.symPos;
			txLineNeg_ff <= tx.symNeg;
			txLineOeN_ff <= driverOff;
		end
	end

	assign txLinePos = txLinePos_ff;
	assign txLineNeg = txLineNeg_ff;
	assign txLineOeN = txLineOeN_ff;

	// fault sense is meaningless while powered down, so alarm is masked too
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			drvAlarm_ff <= 1'b0;
		end else begin
			drvAlarm_ff <= pinLvl[4] && !tdrv_ff[DMON_BIT] && !tpth_ff[TPD_BIT];
		end
	end

	assign driverFailAlarm = drvAlarm_ff;

	// =====================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	tx_term_a: assert property (wrTerm && hostWrData[TTERM_LSB + 2]
		|=> txTermSel == TERM_EXT)
		else $error("tx termination not external");
	rx_term_a: assert property (wrTerm && hostWrData[RTERM_LSB +: 3] == 3'h1
		|=> rxTermSel == TERM_INT120)
		else $error("rx termination not 120 ohm");
	jit_place_a: assert property (wrJitr && hostWrData[JPLACE_LSB +: 2] == 2'h2
		|=> !jitTxPath && !jitRxPath ##1 !jitTxPath && !jitRxPath)
		else $error("attenuator placed for unused code");
	jit_depth_a: assert property (wrJitr && hostWrData[JDEPTH_LSB +: 2] == 2'h1
		|=> jitDepthBits == DEPTH_64)
		else $error("attenuator depth not 64");
	jit_corner_a: assert property (wrJitr && hostWrData[JCORN_BIT]
		|=> jitCornerMilliHz == CORNER_LO)
		else $error("corner not 0.9 Hz");
	pd_float_a: assert property (tpth_ff[TPD_BIT] && $past(tpth_ff[TPD_BIT])
		|=> txLineOeN && !txLinePos && !txLineNeg)
		else $error("powered down driver still active");
	hiz_float_a: assert property (wrTdrv && hostWrData[HIZ_BIT]
		|=> ##1 txLineOeN[*3])
		else $error("high impedance not applied");
	hiz_release_a: assert property (wrTdrv && !hostWrData[HIZ_BIT] && !tpth_ff[TPD_BIT]
		&& !wrTpth |=> ##1 !txLineOeN)
		else $error("driver not restored");
	mon_off_a: assert property (tdrv_ff[DMON_BIT] |=> !driverFailAlarm)
		else $error("alarm with monitor disabled");
	tmpl_user_a: assert property (wrTdrv && hostWrData[3:2] == 2'h3
		|=> tmplSel == TMPL_USER)
		else $error("user template not selected");
	rsvd_read_a: assert property (hostRdEn && hostAddr == ADDR_TDRV
		|=> hostRdValid && hostRdData[7:6] == 2'h0)
		else $error("reserved bits read nonzero");
	reset_val_a: assert property ($rose(nrst) |-> tdrv_ff == RST_TDRV && jitr_ff == RST_JITR)
		else $error("reset defaults wrong");

	cover_jit_rx: cover property (jitRxPath && jitDepthBits == DEPTH_32);
	cover_drive: cover property (!txLineOeN ##1 txLinePos);
	cover_bypass: cover property (tx.mode[1] && tx.symNeg);
endmodule

// *** design/elc_in_sync.sv ***
// elc_in_sync: three-stage synchroniser with agreement filter for pin inputs
// assumes: inputs asynchronous to clk_sys, slower than clk_sys/4
`timescale 1ns/1ps
module elc_in_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] lvl_ff;

	// =====================================================
	// stage chain; s1 only feeds s2
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pinIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lvl_ff <= '0;
		end else begin
			lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
		end
	end

	assign level = lvl_ff;
	assign rise  = s2_ff & s3_ff & ~lvl_ff;
	assign fall  = ~s2_ff & ~s3_ff & lvl_ff;
endmodule

// *** design/elc_pkg.sv ***
// elc_pkg: register map, field layout, reset values and codes of the E1 tx/jitter config block
// assumes: 8-bit host port, one byte per register address
package elc_pkg;
	// =====================================================
	// register addresses
	localparam logic [7:0] ADDR_TERM = 8'h03;
	localparam logic [7:0] ADDR_JITR = 8'h04;
	localparam logic [7:0] ADDR_TPTH = 8'h05;
	localparam logic [7:0] ADDR_TDRV = 8'h06;
	localparam logic [7:0] ADDR_TAMP = 8'h07;
	// =====================================================
	// reset values and writable bits (reserved bits stay zero)
	localparam logic [7:0] RST_TERM  = 8'h00;
	localparam logic [7:0] RST_JITR  = 8'h20;
	localparam logic [7:0] RST_TPTH  = 8'h00;
	localparam logic [7:0] RST_TDRV  = 8'h10;
	localparam logic [7:0] RST_TAMP  = 8'h21;
	localparam logic [7:0] MASK_TERM = 8'h3F;
	localparam logic [7:0] MASK_JITR = 8'h3F;
	localparam logic [7:0] MASK_TPTH = 8'h1F;
	localparam logic [7:0] MASK_TDRV = 8'h3F;
	localparam logic [7:0] MASK_TAMP = 8'h3F;
	// =====================================================
	// field positions
	localparam int TTERM_LSB  = 3;
	localparam int RTERM_LSB  = 0;
	localparam int JLIM_BIT   = 5;
	localparam int JPLACE_LSB = 3;
	localparam int JDEPTH_LSB = 1;
	localparam int JCORN_BIT  = 0;
	localparam int TPD_BIT    = 4;
	localparam int TINV_BIT   = 3;
	localparam int TEDGE_BIT  = 2;
	localparam int TMODE_LSB  = 0;
	localparam int DMON_BIT   = 5;
	localparam int HIZ_BIT    = 4;
	localparam int TMPL_LSB   = 0;
	// =====================================================
	// decoded values
	localparam logic [7:0]  DEPTH_128  = 8'h80;
	localparam logic [7:0]  DEPTH_64   = 8'h40;
	localparam logic [7:0]  DEPTH_32   = 8'h20;
	localparam logic [15:0] CORNER_HI  = 16'h1A90; // 6.8 Hz in mHz
	localparam logic [15:0] CORNER_LO  = 16'h0384; // 0.9 Hz in mHz
	typedef enum logic [1:0] {TERM_INT75 = 2'h0, TERM_INT120 = 2'h1, TERM_EXT = 2'h3} term_type;
	typedef enum logic [1:0] {TMPL_75 = 2'h0, TMPL_120 = 2'h1, TMPL_RSVD = 2'h2,
		TMPL_USER = 2'h3} tmpl_type;
	typedef enum logic [1:0] {SYM_ZERO = 2'h0, SYM_MARK = 2'h1, SYM_VIOL = 2'h3,
		SYM_BIP = 2'h2} sym_type;
endpackage

// *** design/elc_tx_encoder.sv ***
// elc_tx_encoder: HDB3 / AMI line encoder with dual-rail bypass
// assumes: sample pulses from elc_in_sync, one per line clock edge
`timescale 1ns/1ps
module elc_tx_encoder
	import elc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic sampleRise,
	input  wire logic sampleFall,
	input  wire logic dataIn,
	input  wire logic posIn,
	input  wire logic negIn,
	elc_tx_if.enc     tx
);
	sym_type    pipe_ff [4];
	logic [1:0] zeroCnt_ff;
	logic       pulsePar_ff;
	logic       lastPol_ff;
	logic       stb;
	logic       din;
	logic       hdb3;
	logic       fill4;
	sym_type    inSym;
	logic       hold;

	assign hold  = !nrst || tx.powerDown;
	assign stb   = tx.edgeSel ? sampleRise : sampleFall;
	assign din   = dataIn ^ tx.inv;
	assign hdb3  = (tx.mode == 2'h0);
	// fourth zero in a row: violation, preceded by B when pulse count is even
	assign fill4 = hdb3 && !din && (zeroCnt_ff == 2'h3);
	assign inSym = fill4 ? SYM_VIOL : (din ? SYM_MARK : SYM_ZERO);

	// =====================================================
	// four-bit look-ahead pipe; costs four bit times of latency
	always_ff @(posedge clk_sys) begin
		if (hold) begin
			for (int i = 0; i < 4; i++) begin
				pipe_ff[i] <= SYM_ZERO;
			end
		end else if (stb) begin
			pipe_ff[0] <= inSym;
			pipe_ff[1] <= pipe_ff[0];
			pipe_ff[2] <= pipe_ff[1];
			pipe_ff[3] <= (fill4 && !pulsePar_ff) ? SYM_BIP : pipe_ff[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (hold) begin
			zeroCnt_ff  <= 2'h0;
			pulsePar_ff <= 1'b0;
		end else if (stb) begin
			zeroCnt_ff  <= (din || fill4) ? 2'h0 : zeroCnt_ff + 2'h1;
			pulsePar_ff <= fill4 ? 1'b0 : (pulsePar_ff ^ din);
		end
	end

	// =====================================================
	// rail drive, held for the whole bit
	always_ff @(posedge clk_sys) begin
		if (hold) begin
			tx.symPos  <= 1'b0;
			tx.symNeg  <= 1'b0;
			lastPol_ff <= 1'b0;
		end else if (stb) begin
			if (tx.mode[1]) begin
				tx.symPos <= posIn ^ tx.inv;
				tx.symNeg <= negIn ^ tx.inv;
			end else begin
				unique case (pipe_ff[3])
					SYM_MARK, SYM_BIP: begin
						tx.symPos  <= !lastPol_ff;
						tx.symNeg  <= lastPol_ff;
						lastPol_ff <= !lastPol_ff;
					end
					SYM_VIOL: begin
						tx.symPos <= lastPol_ff;
						tx.symNeg <= !lastPol_ff;
					end
					SYM_ZERO: begin
						tx.symPos <= 1'b0;
						tx.symNeg <= 1'b0;
					end
				endcase
			end
		end
	end

	// =====================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	bypass_rails_a: assert property (stb && !hold && tx.mode[1]
		|=> tx.symPos == $past(posIn ^ tx.inv) && tx.symNeg == $past(negIn ^ tx.inv))
		else $error("bypass rails not passed through");
	hdb3_viol_a: assert property (stb && !hold && fill4 |=> pipe_ff[0] == SYM_VIOL)
		else $error("fourth zero not replaced by violation");
	ami_noviol_a: assert property (stb && !hold && tx.mode == 2'h1
		|=> pipe_ff[0] != SYM_VIOL)
		else $error("violation inserted in ami mode");
	edge_ignore_a: assert property (!tx.edgeSel && sampleRise && !hold
		|=> $stable(zeroCnt_ff) && $stable(tx.symPos))
		else $error("sampled on unselected edge");
	cover_hdb3_sub: cover property (stb && fill4 && !pulsePar_ff);
endmodule

// *** design/elc_tx_if.sv ***
// elc_tx_if: transmit path settings and encoded symbol between register block and encoder
// assumes: both ends on clk_sys
`timescale 1ns/1ps
interface elc_tx_if;
	logic [1:0] mode;
	logic       inv;
	logic       edgeSel;
	logic       powerDown;
	logic       symPos;
	logic       symNeg;
	modport ctl (output mode, inv, edgeSel, powerDown, input symPos, symNeg);
	modport enc (input mode, inv, edgeSel, powerDown, output symPos, symNeg);
endinterface

// *** verification/elc_cfg_top_test.sv ***
// elc_cfg_top_test: self-checking bench for the tx / jitter config block
// assumes: elc_pkg and design files compiled first; assertions sit in the design
`timescale 1ns/1ps
module elc_cfg_top_test
	import elc_pkg::*;
;
	// =====================================================
	// signals
	logic        clk_sys;
	logic        nrst;
	logic [7:0]  hostAddr;
	logic        hostWrEn;
	logic        hostRdEn;
	logic [7:0]  hostWrData;
	logic [7:0]  hostRdData;
	logic        hostRdValid;
	logic        txLineClock;
	logic        txSerialIn;
	logic        txPosRail;
	logic        txNegRail;
	logic        driverFaultPin;
	logic        txLinePos;
	logic        txLineNeg;
	logic        txLineOeN;
	logic        txPowerDown;
	logic        driverFailAlarm;
	term_type    txTermSel;
	term_type    rxTermSel;
	logic        jitTxPath;
	logic        jitRxPath;
	logic        jitLimitMode;
	logic [7:0]  jitDepthBits;
	logic [15:0] jitCornerMilliHz;
	tmpl_type    tmplSel;
	logic [5:0]  ampScale;
	int          nMismatch;
	int          testsRun;
	int          marks;
	logic [31:0] seed;
	logic [1:0]  lastRails;
	term_type    expTerm;
	logic [7:0]  expQ[$];
	localparam logic [7:0] ADDRS [5] = '{ADDR_TERM, ADDR_JITR, ADDR_TPTH, ADDR_TDRV, ADDR_TAMP};
	localparam logic [7:0] RSTS  [5] = '{RST_TERM, RST_JITR, RST_TPTH, RST_TDRV, RST_TAMP};
	localparam logic [7:0] MASKS [5] = '{MASK_TERM, MASK_JITR, MASK_TPTH, MASK_TDRV, MASK_TAMP};

	elc_cfg_top u_dut (
		.clk_sys        (clk_sys),
		.nrst           (nrst),
		.hostAddr       (hostAddr),
		.hostWrEn       (hostWrEn),
		.hostRdEn       (hostRdEn),
		.hostWrData     (hostWrData),
		.hostRdData     (hostRdData),
		.hostRdValid    (hostRdValid),
		.txLineClock    (txLineClock),
		.txSerialIn     (txSerialIn),
		.txPosRail      (txPosRail),
		.txNegRail      (txNegRail),
		.driverFaultPin (driverFaultPin),
		.txLinePos      (txLinePos),
		.txLineNeg      (txLineNeg),
		.txLineOeN      (txLineOeN),
		.txPowerDown    (txPowerDown),
		.driverFailAlarm(driverFailAlarm),
		.txTermSel      (txTermSel),
		.rxTermSel      (rxTermSel),
		.jitTxPath       (jitTxPath),
		.jitRxPath       (jitRxPath),
		.jitLimitMode    (jitLimitMode),
		.jitDepthBits    (jitDepthBits),
		.jitCornerMilliHz(jitCornerMilliHz),
		.tmplSel        (tmplSel),
		.ampScale       (ampScale)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// =====================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		testsRun++;
		if (g !== e) begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// decoded outputs settle by the second edge after the strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		hostAddr   <= a;
		hostWrData <= d;
		hostWrEn   <= 1'b1;
		@(posedge clk_sys);
		hostWrEn <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		hostAddr <= a;
		hostRdEn <= 1'b1;
		expQ.push_back(e);
		@(posedge clk_sys);
		hostRdEn <= 1'b0;
	endtask

	// line clock half period of ten system cycles, well under clk_sys/8
	task automatic lclk(input logic v);
		@(posedge clk_sys);
		txLineClock <= v;
		repeat (9) @(posedge clk_sys);
		#1;
	endtask

	task automatic rails(input logic p, input logic n);
		@(posedge clk_sys);
		txPosRail <= p;
		txNegRail <= n;
		txSerialIn <= p;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic bitOut(input logic b);
		rails(b, 1'b0);
		lclk(1'b1);
		lclk(1'b0);
	endtask

	// reset is synchronous, so three low edges clear every stage of the sync chain
	task automatic doReset;
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
	endtask

	task automatic closeOut;
		$display("comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// =====================================================
	// read-data monitor: oldest note against each returned byte
	always @(posedge clk_sys) begin
		if (hostRdValid === 1'b1) begin
			if (expQ.size() == 0) begin
				nMismatch++;
				$display("wrong value hostRdValid expected 0 seen 1");
			end else begin
				chk("hostRdData", {8'h00, expQ.pop_front()}, {8'h00, hostRdData});
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		nMismatch++;
		$display("watchdog expired");
		closeOut();
	end

	// =====================================================
	// main sequence
	initial begin
		{nrst, hostAddr, hostWrEn, hostRdEn, hostWrData} = '0;
		{txLineClock, txSerialIn, txPosRail, txNegRail, driverFaultPin} = '0;
		nMismatch = 0;
		testsRun = 0;
		seed = 32'h0000002C;
		doReset();
		for (int i = 0; i < 5; i++) begin
			rd(ADDRS[i], RSTS[i]);
		end
		#1;
		chk("txLineOeN", 16'h1, txLineOeN);
		chk("jitLimitMode", 16'h1, jitLimitMode);
		chk("ampScale", 16'h0021, ampScale);
		for (int i = 0; i < 5; i++) begin
			seed = xs(seed);
			wr(ADDRS[i], seed[7:0] & MASKS[i]);
			rd(ADDRS[i], seed[7:0] & MASKS[i]);
		end
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h00);
		rd(8'h08, 8'h00);
		$display("test registers done");
		doReset();
		rd(ADDR_TDRV, RST_TDRV);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_TERM, {2'b00, i[2:0], i[2:0]});
			expTerm = i[2] ? TERM_EXT : (i == 1 ? TERM_INT120 : TERM_INT75);
			chk("txTermSel", expTerm, txTermSel);
			chk("rxTermSel", expTerm, rxTermSel);
		end
		for (int i = 0; i < 32; i++) begin
			wr(ADDR_JITR, {3'b001, i[4:0]});
			chk("jitTxPath", {15'h0, i[4:3] == 2'b01}, jitTxPath);
			chk("jitRxPath", {15'h0, i[4:3] == 2'b11}, jitRxPath);
			chk("jitDepth", i[2] ? DEPTH_32 : (i[1] ? DEPTH_64 : DEPTH_128), jitDepthBits);
			chk("jitCorner", i[0] ? CORNER_LO : CORNER_HI, jitCornerMilliHz);
		end
		wr(ADDR_JITR, 8'h00);
		chk("jitLimitMode", 16'h0, jitLimitMode);
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_TDRV, {4'h1, i[3:0]});
			chk("tmplSel", i < 2 ? i : (i > 11 ? TMPL_USER : TMPL_RSVD), tmplSel);
			chk("txLineOeN", 16'h1, txLineOeN);
		end
		wr(ADDR_TERM, 8'h00);
		wr(ADDR_TDRV, 8'h10);
		chk("tmplSel", TMPL_75, tmplSel);
		wr(ADDR_TERM, 8'h24);
		wr(ADDR_TDRV, 8'h11);
		chk("tmplSel", TMPL_120, tmplSel);
		chk("txTermSel", TERM_EXT, txTermSel);
		$display("test decode done");
		wr(ADDR_TDRV, 8'h01);
		chk("txLineOeN", 16'h0, txLineOeN);
		wr(ADDR_TPTH, 8'h02);
		rails(1'b1, 1'b0);
		lclk(1'b1);
		chk("txLinePos", 16'h0, txLinePos);
		lclk(1'b0);
		chk("txLineRails", 16'h2, {txLinePos, txLineNeg});
		wr(ADDR_TPTH, 8'h0A);
		lclk(1'b1);
		lclk(1'b0);
		chk("txLineRails", 16'h1, {txLinePos, txLineNeg});
		wr(ADDR_TPTH, 8'h06);
		rails(1'b1, 1'b0);
		lclk(1'b1);
		chk("txLineRails", 16'h2, {txLinePos, txLineNeg});
		rails(1'b0, 1'b1);
		lclk(1'b0);
		chk("txLineRails", 16'h2, {txLinePos, txLineNeg});
		wr(ADDR_TPTH, 8'h12);
		chk("txPowerDown", 16'h1, txPowerDown);
		chk("txLineOeN", 16'h1, txLineOeN);
		wr(ADDR_TPTH, 8'h01);
		chk("txPowerDown", 16'h0, txPowerDown);
		chk("txLineOeN", 16'h0, txLineOeN);
		$display("test line bypass done");
		// pipe latency is four bits, so judge only from the eighth bit on
		for (int i = 0; i < 12; i++) begin
			bitOut(1'b1);
			if (i > 6) begin
				chk("amiRails", {14'h0, ~lastRails}, {txLinePos, txLineNeg});
			end
			lastRails = {txLinePos, txLineNeg};
		end
		for (int i = 0; i < 12; i++) begin
			bitOut(1'b0);
			if (i > 6) begin
				chk("amiRails", 16'h0, {txLinePos, txLineNeg});
			end
		end
		wr(ADDR_TPTH, 8'h00);
		marks = 0;
		for (int i = 0; i < 12; i++) begin
			bitOut(1'b0);
			if (i > 7) begin
				marks = marks + (txLinePos | txLineNeg);
			end
		end
		chk("hdb3Marks", 16'h1, {15'h0, marks > 0});
		$display("test line coding done");
		@(posedge clk_sys);
		driverFaultPin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk("driverFailAlarm", 16'h1, driverFailAlarm);
		wr(ADDR_TDRV, 8'h21);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("driverFailAlarm", 16'h0, driverFailAlarm);
		$display("test monitor done");
		repeat (3) @(posedge clk_sys);
		closeOut();
	end
endmodule
